// [logic/afcs_defs.svh]
// constants of the amplifier fault, clip and sequencing block
// Function
// (RULE1) The clip warning output goes low while the audio output is near its clipping point.
// (RULE2) Channel 0 modulation index reads at address 98 and channel 1 at address 102.
// (RULE3) Bit 7 of address 10 turns soft clipping on, and clearing it leaves ordinary clipping.
// (RULE4) The fault output goes low as soon as any fault source becomes active.
// (RULE5) Address 124 returns the live state of every fault source.
// (RULE6) Address 109 keeps a sticky record of every fault that has occurred.
// (RULE7) The sticky record clears when the host sets and then clears bit 2 of address 45.
// (RULE8) Both fault registers share one layout, from dc offset at bit 7 to bit0 fault at bit 0.
// (RULE9) The two select pins choose the output stage arrangement from four options.
// (RULE10) At power-up the host keeps the amplifier disabled and muted until supplies are stable.
// (RULE11) The host starts the audio clock before enabling the amplifier.
// (RULE12) The host programs the registers after enabling and only then unmutes.
// (RULE13) At shutdown the host mutes, then disables, then removes the supplies.
// (RULE14) The register bank holds 128 bytes, 0 to 80 writable and 96 to 127 read-only.
// (RULE15) The fault output stays low while any live fault bit is set and returns high after.
// (RULE16) Writes to the read-only status registers are ignored.
`ifndef AFCS_DEFS_SVH
`define AFCS_DEFS_SVH
`define AFCS_ADDR_W         7
`define AFCS_DATA_W         8
`define AFCS_RW_LAST        7'h50
`define AFCS_RO_FIRST       7'h60
`define AFCS_SOFT_CLIP_CFG  7'h0a
`define AFCS_SOFT_CLIP_BIT  7
`define AFCS_FAULT_CTRL     7'h2d
`define AFCS_LOG_CLEAR_BIT  2
`define AFCS_MOD_IDX_CH0    7'h62
`define AFCS_MOD_IDX_CH1    7'h66
`define AFCS_FAULT_HISTORY  7'h6d
`define AFCS_FAULT_LIVE     7'h7c
`define AFCS_RESET_BYTE     8'h00
`define AFCS_BIT_DC         7
`define AFCS_BIT_PPS        6
`define AFCS_BIT_OTE        5
`define AFCS_BIT_OTW        4
`define AFCS_BIT_UV         3
`define AFCS_BIT_CLK        2
`define AFCS_BIT_OC         1
`define AFCS_BIT_B0         0
`endif

// [logic/afcs_pkg.sv]
// types of the amplifier fault, clip and sequencing block
package afcs_pkg;
   typedef enum logic [1:0] {
      parallel_bridged_mode,
      afcs_se2_btl1,
      afcs_btl2,
      afcs_se4
   } afcs_cfg_e;
   typedef logic [7:0] afcs_byte_t;
   typedef logic [6:0] afcs_addr_t;
endpackage : afcs_pkg

// [logic/afcs_sync.sv]
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module afcs_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;
   if (WIDTH < 1) begin : g_bad_width
      $error("afcs_sync width must be positive");
   end
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule : afcs_sync
`default_nettype wire

// [logic/afcs_top.sv]
// register bank, fault logging, clip pin and output configuration
`timescale 1ns/1ps
`default_nettype none
`include "afcs_defs.svh"
module afcs_top #(
   parameter int NUM_FAULTS = 8
) (
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   // register port from the serial controller, same clock
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire afcs_pkg::afcs_addr_t reg_addr_i,
   input  wire afcs_pkg::afcs_byte_t reg_wdata_i,
   output afcs_pkg::afcs_byte_t   reg_rdata_o,
   output logic                   reg_rvalid_o,
   // modulator side, same clock
   input  wire afcs_pkg::afcs_byte_t mod_index_ch0_i,
   input  wire afcs_pkg::afcs_byte_t mod_index_ch1_i,
   input  wire logic              near_clip_i,
   output logic                   soft_clip_en_o,
   // fault sources, asynchronous levels
   input  wire logic [7:0]        fault_src_i,
   // output configuration pins
   input  wire logic              output_cfg_sel0_i,
   input  wire logic              output_cfg_sel1_i,
   output afcs_pkg::afcs_cfg_e    output_cfg_o,
   // open-drain pins, enable high while pulling low
   output logic                   clip_n_o,
   output logic                   clip_n_oe_o,
   output logic                   fault_n_o,
   output logic                   fault_n_oe_o
);
   import afcs_pkg::*;

   afcs_byte_t rw_bank [0:80];
   afcs_byte_t fault_live;
   afcs_byte_t fault_history;
   afcs_byte_t mod_index_ch0;
   afcs_byte_t mod_index_ch1;
   logic [7:0] fault_sync;
   logic [1:0] sel_sync;
   logic       clear_prev;
   logic       clear_now;
   logic       clear_fall;
   logic       wr_ok;

   // fault vector is fixed at one byte
   if (NUM_FAULTS != 8) begin : g_bad_num_faults
      $error("afcs_top supports exactly eight fault sources");
   end

   function automatic logic is_writable(input afcs_addr_t a);
      is_writable = (a <= `AFCS_RW_LAST);
   endfunction : is_writable

   afcs_sync #(
      .WIDTH (10)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .async_i   ({output_cfg_sel1_i, output_cfg_sel0_i, fault_src_i}),
      .sync_o    ({sel_sync, fault_sync})
   );

   // writes only land in the read/write range
   // (RULE16) status writes dropped
   assign wr_ok = reg_wr_i && is_writable(reg_addr_i);

   // (RULE14) read/write bank storage
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i <= 80; i++) begin
            rw_bank[i] <= `AFCS_RESET_BYTE;
         end
      end else if (wr_ok) begin
         rw_bank[reg_addr_i] <= reg_wdata_i;
      end
   end

   // (RULE3) soft clip enable bit
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         soft_clip_en_o <= 1'b0;
      end else begin
         soft_clip_en_o <= rw_bank[`AFCS_SOFT_CLIP_CFG][`AFCS_SOFT_CLIP_BIT];
      end
   end

   // (RULE5) live fault image
   // (RULE8) bit order kept from sources
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         fault_live <= `AFCS_RESET_BYTE;
      end else begin
         fault_live <= fault_sync;
      end
   end

   assign clear_now  = rw_bank[`AFCS_FAULT_CTRL][`AFCS_LOG_CLEAR_BIT];
   assign clear_fall = clear_prev && !clear_now;

   // (RULE7) falling-edge detect on clear bit
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         clear_prev <= 1'b0;
      end else begin
         clear_prev <= clear_now;
      end
   end

   // (RULE6) sticky history, set beats clear
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         fault_history <= `AFCS_RESET_BYTE;
      end else if (clear_fall) begin
         fault_history <= fault_live;
      end else begin
         fault_history <= fault_history | fault_live;
      end
   end

   // (RULE2) modulation index capture
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         mod_index_ch0 <= `AFCS_RESET_BYTE;
         mod_index_ch1 <= `AFCS_RESET_BYTE;
      end else begin
         mod_index_ch0 <= mod_index_ch0_i;
         mod_index_ch1 <= mod_index_ch1_i;
      end
   end

   // read port, one cycle after request
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o  <= `AFCS_RESET_BYTE;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            if (is_writable(reg_addr_i)) begin
               reg_rdata_o <= rw_bank[reg_addr_i];
            end else begin
               case (reg_addr_i)
                  `AFCS_MOD_IDX_CH0:   reg_rdata_o <= mod_index_ch0;
                  `AFCS_MOD_IDX_CH1:   reg_rdata_o <= mod_index_ch1;
                  `AFCS_FAULT_HISTORY: reg_rdata_o <= fault_history;
                  `AFCS_FAULT_LIVE:    reg_rdata_o <= fault_live;
                  default:             reg_rdata_o <= `AFCS_RESET_BYTE;
               endcase
            end
         end
      end
   end

   // (RULE1) clip pin pulls low near clipping
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         clip_n_o    <= 1'b1;
         clip_n_oe_o <= 1'b0;
      end else begin
         clip_n_o    <= !near_clip_i;
         clip_n_oe_o <= near_clip_i;
      end
   end

   // (RULE4) fault pin low on any source
   // (RULE15) released when all clear
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         fault_n_o    <= 1'b1;
         fault_n_oe_o <= 1'b0;
      end else begin
         fault_n_o    <= !(|fault_sync);
         fault_n_oe_o <= |fault_sync;
      end
   end

   // (RULE9) output stage selection
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         output_cfg_o <= parallel_bridged_mode;
      end else begin
         case ({sel_sync[0], sel_sync[1]})
            2'b00:   output_cfg_o <= parallel_bridged_mode;
            2'b01:   output_cfg_o <= afcs_se2_btl1;
            2'b10:   output_cfg_o <= afcs_btl2;
            default: output_cfg_o <= afcs_se4;
         endcase
      end
   end
endmodule : afcs_top
`default_nettype wire

// [test/afcs_top_assertions.sv]
// concurrent checks on the register, clip and fault ports
`timescale 1ns/1ps
`default_nettype none
module afcs_top_assertions (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [6:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_rvalid_o,
   input  wire logic       near_clip_i,
   input  wire logic       soft_clip_en_o,
   input  wire logic [7:0] fault_src_i,
   input  wire logic       clip_n_o,
   input  wire logic       clip_n_oe_o,
   input  wire logic       fault_n_o,
   input  wire logic       fault_n_oe_o
);
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered");
   rd_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
      else $error("spurious read answer");
   soft_follow_a: assert property (
      reg_wr_i && reg_addr_i == 7'h0a |=> ##1 soft_clip_en_o == $past(reg_wdata_i[7], 2))
      else $error("soft clip not following write");
   soft_hold_a: assert property (
      (!(reg_wr_i && reg_addr_i == 7'h0a)) [*3] |=> $stable(soft_clip_en_o))
      else $error("soft clip changed without write");
   clip_on_a: assert property (near_clip_i |=> clip_n_oe_o && !clip_n_o)
      else $error("clip pin not pulled");
   clip_off_a: assert property (!near_clip_i |=> !clip_n_oe_o)
      else $error("clip pin pulled without cause");
   fault_on_a: assert property (
      (fault_src_i != 8'h00) [*3] |=> fault_n_oe_o && !fault_n_o)
      else $error("fault pin not pulled");
   fault_off_a: assert property ((fault_src_i == 8'h00) [*3] |=> !fault_n_oe_o)
      else $error("fault pin held after sources cleared");
endmodule : afcs_top_assertions
`default_nettype wire

// [test/afcs_host_model.sv]
// host microcontroller model: register strobes and power pins
`timescale 1ns/1ps
`default_nettype none
module afcs_host_model (
   input  wire logic       sys_clk_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i,
   output logic            wr_o,
   output logic            rd_o,
   output logic [6:0]      addr_o,
   output logic [7:0]      wdata_o
);
   logic enable_n = 1'b1;
   logic mute_n = 1'b0;
   initial {wr_o, rd_o, addr_o, wdata_o} = '0;
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      {wr_o, addr_o, wdata_o} <= {1'b1, a, v};
      @(posedge sys_clk_i);
      {wr_o, wdata_o} <= {1'b0, ~v};
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      @(posedge sys_clk_i);
      {rd_o, addr_o} <= {1'b1, a};
      @(posedge sys_clk_i);
      rd_o <= 1'b0;
      @(posedge sys_clk_i);
      v = rvalid_i ? rdata_i : 8'hxx;
   endtask : rd
   // enable on running clock, unmute after setup
   task automatic power_up(input logic [7:0] cfg);
      @(posedge sys_clk_i);
      enable_n <= 1'b0;
      wr(7'h0a, cfg);
      mute_n <= 1'b1;
   endtask : power_up
   task automatic power_down();
      @(posedge sys_clk_i);
      mute_n <= 1'b0;
      @(posedge sys_clk_i);
      enable_n <= 1'b1;
   endtask : power_down
   task automatic log_clear();
      wr(7'h2d, 8'h04);
      wr(7'h2d, 8'h00);
   endtask : log_clear
endmodule : afcs_host_model
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the fault, clip and register block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import afcs_pkg::*;
   logic       sys_clk_i, reset_i, reg_wr_i, reg_rd_i, reg_rvalid_o, near_clip_i;
   logic       soft_clip_en_o, output_cfg_sel0_i, output_cfg_sel1_i;
   logic       clip_n_o, clip_n_oe_o, fault_n_o, fault_n_oe_o;
   logic [6:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, mod_index_ch0_i, mod_index_ch1_i, fault_src_i, d, hist;
   afcs_cfg_e  output_cfg_o;
   int         n_fail, total_checks;
   afcs_top u_afcs_top (.sys_clk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
      .reg_rdata_o, .reg_rvalid_o, .mod_index_ch0_i, .mod_index_ch1_i, .near_clip_i,
      .soft_clip_en_o, .fault_src_i, .output_cfg_sel0_i, .output_cfg_sel1_i, .output_cfg_o,
      .clip_n_o, .clip_n_oe_o, .fault_n_o, .fault_n_oe_o);
   afcs_host_model u_host (.sys_clk_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
      .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
      u_host.rd(a, d);
      chk($sformatf("byte at %h", a), exp, d);
   endtask : rdchk
   task automatic t_bank();
      rdchk(7'h2d, 8'h00);
      u_host.wr(7'h50, 8'ha5);
      u_host.wr(7'h51, 8'h3c);
      rdchk(7'h50, 8'ha5);
      rdchk(7'h51, 8'h00);
      rdchk(7'h70, 8'h00);
   endtask : t_bank
   task automatic t_clip();
      @(posedge sys_clk_i);
      {near_clip_i, mod_index_ch0_i, mod_index_ch1_i} <= {1'b1, 8'h5a, 8'hc3};
      repeat (2) @(posedge sys_clk_i);
      chk("clip pin", 8'h02, {6'h00, clip_n_oe_o, clip_n_o});
      rdchk(7'h62, 8'h5a);
      rdchk(7'h66, 8'hc3);
      near_clip_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      chk("clip pin", 8'h01, {6'h00, clip_n_oe_o, clip_n_o});
   endtask : t_clip
   task automatic t_soft();
      u_host.wr(7'h0a, 8'h80);
      repeat (2) @(posedge sys_clk_i);
      chk("soft clip", 8'h01, {7'h00, soft_clip_en_o});
      u_host.wr(7'h0a, 8'h7f);
      repeat (2) @(posedge sys_clk_i);
      chk("soft clip", 8'h00, {7'h00, soft_clip_en_o});
      rdchk(7'h0a, 8'h7f);
   endtask : t_soft
   task automatic t_fault();
      hist = 8'h00;
      for (int i = 0; i < 8; i++) begin
         fault_src_i <= 8'h01 << i;
         repeat (5) @(posedge sys_clk_i);
         chk("fault pin", 8'h02, {6'h00, fault_n_oe_o, fault_n_o});
         rdchk(7'h7c, 8'h01 << i);
         hist = hist | (8'h01 << i);
         rdchk(7'h6d, hist);
         fault_src_i <= 8'h00;
         repeat (5) @(posedge sys_clk_i);
         chk("fault pin", 8'h01, {6'h00, fault_n_oe_o, fault_n_o});
      end
      u_host.wr(7'h6d, 8'h00);
      u_host.wr(7'h7c, 8'h55);
      rdchk(7'h6d, 8'hff);
      rdchk(7'h7c, 8'h00);
   endtask : t_fault
   task automatic t_clear();
      fault_src_i <= 8'h08;
      repeat (5) @(posedge sys_clk_i);
      u_host.log_clear();
      repeat (2) @(posedge sys_clk_i);
      rdchk(7'h6d, 8'h08);
      fault_src_i <= 8'h00;
      repeat (5) @(posedge sys_clk_i);
      rdchk(7'h7c, 8'h00);
      rdchk(7'h6d, 8'h08);
      u_host.log_clear();
      repeat (2) @(posedge sys_clk_i);
      rdchk(7'h6d, 8'h00);
   endtask : t_clear
   task automatic t_cfg();
      for (int v = 0; v < 4; v++) begin
         {output_cfg_sel0_i, output_cfg_sel1_i} <= 2'(v);
         repeat (5) @(posedge sys_clk_i);
         chk("output cfg", 8'(v), {6'h00, output_cfg_o});
      end
   endtask : t_cfg
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   initial begin
      {n_fail, total_checks} = '0;
      {reset_i, near_clip_i, output_cfg_sel0_i, output_cfg_sel1_i} = 4'b1000;
      {mod_index_ch0_i, mod_index_ch1_i, fault_src_i} = '0;
      repeat (16) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      u_host.power_up(8'h00);
      t_bank();
      t_clip();
      t_soft();
      t_fault();
      t_clear();
      t_cfg();
      u_host.power_down();
      finish_test();
   end
   // run needs well under a thousand cycles
   initial begin
      #20000;
      n_fail++;
      finish_test();
   end
endmodule : tb
bind afcs_top afcs_top_assertions u_chk (.sys_clk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
   .reg_wdata_i, .reg_rvalid_o, .near_clip_i, .soft_clip_en_o, .fault_src_i, .clip_n_o,
   .clip_n_oe_o, .fault_n_o, .fault_n_oe_o);
`default_nettype wire
